// ==== bench/code_source_model.sv ====
// Code source model: drives the select code pins toward a goal code
// Assumes the bench sets goal; pins change just after a rising edge
`timescale 1ns/1ns
module code_source_model #(
    parameter int PACE = 2
) (
    input wire logic ref_clk,
    input wire logic [7:0] goal,
    output logic [7:0] code = 8'h10
);
    // ==============================================================
    // Pacing
    int cnt = 0;
    // One LSB per PACE cycles keeps the output slope under control
    always @(posedge ref_clk) begin
        cnt <= (cnt == PACE - 1) ? 0 : cnt + 1;
        if (cnt == PACE - 1 && code != goal) begin
            code <= (code < goal) ? code + 8'h01 : code - 8'h01;
        end
    end
endmodule

// ==== bench/dynamic_vid_reference_stepper_bench.sv ====
// Bench for the reference stepper: pins, faults and registers
// Assumes a 25 MHz clock and the code source model on the code pins
`timescale 1ns/1ns
`include "vid_stepper_regs.svh"
module dynamic_vid_reference_stepper_bench;
    // ==============================================================
    // Signals
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic logicSupplyOk = 1'b0, driverSupplyOk = 1'b1, outputEnableInput = 1'b1;
    logic underVoltCmp = 1'b0, overVoltCmp = 1'b0, outputInWindow = 1'b1;
    logic [7:0] goal = 8'h10, voltageSelectCode, referenceCode;
    logic [20:0] referenceMicrovolts;
    logic gateDriveEnable, lowSideClamp, overvoltageTrip, undervoltageTrip, powerOkOutput;
    logic rampInProgressFlag, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_count = 0, checks = 0, cyc = 0;

    // ==============================================================
    // Clock, cycle count and instances
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    code_source_model #(.PACE(2)) src (.ref_clk, .goal, .code(voltageSelectCode));
    dynamic_vid_reference_stepper uut (.ref_clk, .reset_n, .voltageSelectCode,
        .logicSupplyOk, .driverSupplyOk, .outputEnableInput, .underVoltCmp, .overVoltCmp,
        .outputInWindow, .referenceCode, .referenceMicrovolts, .gateDriveEnable,
        .lowSideClamp, .overvoltageTrip, .undervoltageTrip, .powerOkOutput,
        .rampInProgressFlag, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // ==============================================================
    // Reporting and bus tasks
    task report_and_stop;
        $display("Counts: %0d compares, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask
    task hang(input string what);
        err_count++;
        $display("[FAIL] %0t timeout on %s", $time, what);
        report_and_stop();
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Address and data go out together; each is released when taken
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 100) hang("write");
        check(32'(s_axi_bresp), 32'h00000000, "write response");
        s_axi_bready <= 1'b0;
    endtask
    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 100) hang("read");
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task wait_ref(input logic [7:0] c, input int b);
        int n;
        for (n = 0; n < b && referenceCode !== c; n++) @(posedge ref_clk);
        if (n == b) hang("reference");
    endtask
    // Cycles between the first two reference moves of a ramp
    task step_gap(output int g);
        logic [7:0] r;
        int n;
        r = referenceCode;
        for (n = 0; n < 400 && referenceCode === r; n++) @(posedge ref_clk);
        r = referenceCode;
        for (g = 0; g < 400 && referenceCode === r; g++) @(posedge ref_clk);
        if (g == 400) hang("step");
    endtask

    // ==============================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int g;
        int t0;
        tick(20);
        reset_n <= 1'b1;
        tick(60);
        check(32'(gateDriveEnable), 32'h00000000, "gate without supply");
        axi_read(`OFS_CTRL, d, r);
        check(d, 32'h00000000, "ctrl reset");
        axi_read(8'h40, d, r);
        check(32'(r), 32'h00000002, "unmapped read");
        axi_write(`OFS_IRQ_ENABLE, 32'h00000001);
        axi_read(`OFS_IRQ_ENABLE, d, r);
        check(d, 32'h00000001, "irq enable");
        $display("Test registers done");
        // Soft start once both supplies are good
        logicSupplyOk <= 1'b1;
        wait_ref(8'h10, 1000);
        for (g = 0; g < 200 && powerOkOutput !== 1'b1; g++) tick(1);
        if (g == 200) hang("power ok");
        check(32'(powerOkOutput), 32'h00000001, "power ok");
        check(32'(referenceMicrovolts), 32'h00013C68, "trimmed ref");
        axi_write(`OFS_IRQ_CLEAR, 32'h0000000F);
        $display("Test soft start done");
        // Fast step up with a trip pulse inside the ramp
        goal <= 8'h14;
        step_gap(g);
        check(32'(g), 32'h00000019, "fast step period");
        overVoltCmp <= 1'b1;
        tick(4);
        overVoltCmp <= 1'b0;
        wait_ref(8'h14, 400);
        t0 = cyc;
        check(32'(referenceMicrovolts), 32'h00019E10, "fine ref");
        check(32'(overvoltageTrip), 32'h00000000, "trip in ramp");
        tick(3);
        check(32'(irq), 32'h00000001, "irq set");
        axi_read(`OFS_IRQ_STATUS, d, r);
        check(d & 32'h00000001, 32'h00000001, "ramp done");
        axi_write(`OFS_IRQ_CLEAR, 32'h00000001);
        tick(3);
        check(32'(irq), 32'h00000000, "irq clear");
        // Trips stay masked for the 32-step tail, then re-arm
        while (cyc < t0 + 740) tick(1);
        overVoltCmp <= 1'b1;
        tick(6);
        check(32'(overvoltageTrip), 32'h00000000, "trip in tail");
        overVoltCmp <= 1'b0;
        while (cyc < t0 + 900) tick(1);
        overVoltCmp <= 1'b1;
        tick(6);
        check(32'(overvoltageTrip), 32'h00000001, "trip armed");
        check(32'(lowSideClamp), 32'h00000001, "clamp");
        overVoltCmp <= 1'b0;
        $display("Test fast step done");
        // Enable low clears the latched fault and holds everything off
        outputEnableInput <= 1'b0;
        tick(10);
        check(32'(overvoltageTrip), 32'h00000000, "fault cleared");
        check(32'(powerOkOutput), 32'h00000000, "power ok low");
        check(32'({gateDriveEnable, lowSideClamp}), 32'h00000000, "fets off");
        axi_write(`OFS_CTRL, 32'h00000001);
        outputEnableInput <= 1'b1;
        wait_ref(8'h14, 3000);
        // Six-bit mode: slow step down with the flag through the tail
        goal <= 8'h12;
        step_gap(g);
        check(32'(g), 32'h00000064, "slow step period");
        check(32'(rampInProgressFlag), 32'h00000001, "flag in ramp");
        check(32'(powerOkOutput), 32'h00000000, "power ok masked");
        wait_ref(8'h12, 400);
        t0 = cyc;
        check(32'(referenceMicrovolts), 32'h0006DDD0, "coarse ref");
        tick(20);
        check(32'(rampInProgressFlag), 32'h00000001, "flag in tail");
        for (g = 0; g < 3500 && rampInProgressFlag === 1'b1; g++) tick(1);
        if (g == 3500) hang("flag");
        check(32'(cyc - t0 > 3100 && cyc - t0 < 3400), 32'h00000001, "tail length");
        $display("Test six-bit step done");
        // Sustained undervoltage latches with all drivers off
        underVoltCmp <= 1'b1;
        tick(300);
        underVoltCmp <= 1'b0;
        tick(50);
        check(32'(undervoltageTrip), 32'h00000001, "uv latched");
        check(32'(gateDriveEnable), 32'h00000000, "uv gates off");
        $display("Test undervoltage done");
        report_and_stop();
    end
endmodule

// ==== common/vid_stepper_pkg.sv ====
// Types shared by the reference stepper and its helpers
// Assumes the constants of vid_stepper_regs.svh
package vid_stepper_pkg;

    // ==============================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_SOFT = 3'b001,
        ST_IDLE = 3'b010,
        ST_CONFIRM = 3'b011,
        ST_ARMED = 3'b100,
        ST_RAMP = 3'b101
    } state_t;

endpackage

// ==== common/vid_stepper_regs.svh ====
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit AXI4-Lite register window and a 25 MHz ref_clk
`ifndef VID_STEPPER_REGS_SVH
`define VID_STEPPER_REGS_SVH

// ==============================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_REF 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_ENABLE 8'h10
`define OFS_IRQ_CLEAR 8'h14

// ==============================================================
// Field positions and reset values
`define CTRL_SIX_BIT 0
`define CTRL_RESET 1'b0
`define IRQ_RAMP_DONE 0
`define IRQ_SOFT_DONE 1
`define IRQ_UV_FAULT 2
`define IRQ_OV_FAULT 3
`define IRQ_BITS 4
`define SIX_BIT_CODE_MASK 8'h3F

// ==============================================================
// Timing and reference scaling
`define REF_CLK_HZ 25000000
`define STEP_FAST_HZ 1000000
`define STEP_SLOW_HZ 250000
`define STEP_FAST_DIV (`REF_CLK_HZ / `STEP_FAST_HZ)
`define STEP_SLOW_DIV (`REF_CLK_HZ / `STEP_SLOW_HZ)
`define MASK_TAIL_STEPS 6'h20
`define LSB_FINE_UV 6250
`define LSB_COARSE_UV 25000
`define TRIM_UV 19000

`endif

// ==== hdl/dynamic_vid_reference_stepper.sv ====
// Reference stepper: confirms code changes, slews the reference, masks trips
// Assumes pins are asynchronous, comparators are analog, AXI4-Lite on ref_clk
`timescale 1ns/1ns
`include "vid_stepper_regs.svh"
module dynamic_vid_reference_stepper (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [7:0] voltageSelectCode,
    input wire logic logicSupplyOk,
    input wire logic driverSupplyOk,
    input wire logic outputEnableInput,
    input wire logic underVoltCmp,
    input wire logic overVoltCmp,
    input wire logic outputInWindow,
    output logic [7:0] referenceCode,
    output logic [20:0] referenceMicrovolts,
    output logic gateDriveEnable,
    output logic lowSideClamp,
    output logic overvoltageTrip,
    output logic undervoltageTrip,
    output logic powerOkOutput,
    output logic rampInProgressFlag,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        vid_stepper_pkg::state_t state;
        logic [7:0] refCode;
        logic [7:0] target;
        logic [7:0] candidate;
        logic [5:0] maskCnt;
        logic ssDone;
        logic uvArm;
        logic uvFault;
        logic ovFault;
        logic gateEnable;
        logic lowClamp;
        logic powerOk;
        logic rampFlag;
        logic [20:0] refUv;
        logic sixBit;
        logic [`IRQ_BITS-1:0] irqStatus;
        logic [`IRQ_BITS-1:0] irqEnable;
        logic irq;
        logic awTaken;
        logic wTaken;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } core_t;

    core_t s_q, s_d;
    logic [7:0] codeSync;
    logic [4:0] pinSync;
    logic stepRise;
    logic stepFall;
    logic [7:0] codeNow;
    logic enabled;
    logic masking;
    logic [`IRQ_BITS-1:0] events;
    logic [`IRQ_BITS-1:0] clearBits;

    // ==============================================================
    // One LSB toward the goal, direction from the compare
    function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] goal);
        if (goal > cur) begin
            return cur + 8'h01;
        end else if (goal < cur) begin
            return cur - 8'h01;
        end
        return cur;
    endfunction

    // Reference in microvolts; in eight-bit mode the trimmed value clamps to zero near zero to avoid wrap
    function automatic logic [20:0] to_uv(input logic [7:0] code, input logic six);
        int uv;
        uv = six ? int'(code) * `LSB_COARSE_UV : int'(code) * `LSB_FINE_UV;
        if (!six) begin
            uv = (uv > `TRIM_UV) ? uv - `TRIM_UV : 0;
        end
        return 21'(uv);
    endfunction

    // ==============================================================
    // Pin synchronisers and step clock
    pin_sync #(.WIDTH(8)) codeSyncInst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pinIn(voltageSelectCode),
        .pinOut(codeSync)
    );

    pin_sync #(.WIDTH(5)) ctlSyncInst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pinIn({logicSupplyOk, driverSupplyOk, outputEnableInput, underVoltCmp, overVoltCmp}),
        .pinOut(pinSync)
    );

    step_clock_divider stepDivInst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .slowMode(s_q.sixBit),
        .stepRise(stepRise),
        .stepFall(stepFall)
    );

    // ==============================================================
    // Whole next state of the block
    always_comb begin
        s_d = s_q;
        events = '0;
        clearBits = '0;
        codeNow = s_q.sixBit ? (codeSync & `SIX_BIT_CODE_MASK) : codeSync;
        enabled = pinSync[4] && pinSync[3] && pinSync[2];
        masking = (s_q.state == vid_stepper_pkg::ST_ARMED)
            || (s_q.state == vid_stepper_pkg::ST_RAMP) || (s_q.maskCnt != 6'h00);

        // Supply or enable loss drops everything and clears latches
        if (!enabled) begin
            s_d.state = vid_stepper_pkg::ST_OFF;
            s_d.refCode = 8'h00;
            s_d.ssDone = 1'b0;
            s_d.uvFault = 1'b0;
            s_d.ovFault = 1'b0;
            s_d.uvArm = 1'b0;
            s_d.maskCnt = 6'h00;
        end else begin
            unique case (s_q.state)
                vid_stepper_pkg::ST_OFF: begin
                    s_d.target = codeNow;
                    s_d.state = vid_stepper_pkg::ST_SOFT;
                end
                vid_stepper_pkg::ST_SOFT: begin
                    if (stepRise) begin
                        if (s_q.refCode == s_q.target) begin
                            s_d.ssDone = 1'b1;
                            s_d.state = vid_stepper_pkg::ST_IDLE;
                            events[`IRQ_SOFT_DONE] = 1'b1;
                        end else begin
                            s_d.refCode = step_toward(s_q.refCode, s_q.target);
                        end
                    end
                end
                vid_stepper_pkg::ST_IDLE: begin
                    if (stepRise && codeNow != s_q.target) begin
                        s_d.candidate = codeNow;
                        s_d.state = vid_stepper_pkg::ST_CONFIRM;
                    end
                end
                vid_stepper_pkg::ST_CONFIRM: begin
                    if (stepFall) begin
                        s_d.state = (codeNow == s_q.candidate) ? vid_stepper_pkg::ST_ARMED
                            : vid_stepper_pkg::ST_IDLE;
                    end
                end
                vid_stepper_pkg::ST_ARMED, vid_stepper_pkg::ST_RAMP: begin
                    // Code pins are not looked at here, so changes are ignored
                    if (stepRise) begin
                        s_d.target = s_q.candidate;
                        s_d.refCode = step_toward(s_q.refCode, s_q.candidate);
                        if (s_d.refCode == s_q.candidate) begin
                            s_d.state = vid_stepper_pkg::ST_IDLE;
                            s_d.maskCnt = `MASK_TAIL_STEPS;
                            events[`IRQ_RAMP_DONE] = 1'b1;
                        end else begin
                            s_d.state = vid_stepper_pkg::ST_RAMP;
                        end
                    end
                end
                default: s_d.state = vid_stepper_pkg::ST_OFF;
            endcase

            // Tail of the protection mask counts step clocks
            if (stepRise && s_q.maskCnt != 6'h00 && s_d.maskCnt == s_q.maskCnt) begin
                s_d.maskCnt = s_q.maskCnt - 6'h01;
            end

            // Undervoltage must persist across a whole step period
            if (stepRise) begin
                s_d.uvArm = pinSync[1];
                if (pinSync[1] && s_q.uvArm && !masking && !s_q.uvFault) begin
                    s_d.uvFault = 1'b1;
                    events[`IRQ_UV_FAULT] = 1'b1;
                end
            end
            if (pinSync[0] && !masking && !s_q.ovFault) begin
                s_d.ovFault = 1'b1;
                events[`IRQ_OV_FAULT] = 1'b1;
            end
        end

        // Output drive derived from the new state
        s_d.gateEnable = enabled && !s_d.uvFault && !s_d.ovFault
            && (s_d.state != vid_stepper_pkg::ST_OFF);
        s_d.lowClamp = enabled && s_d.ovFault && !s_d.uvFault;
        s_d.powerOk = enabled && s_d.ssDone && pinSync[0] == 1'b0 && outputInWindow
            && !s_d.uvFault && !s_d.ovFault && !(s_q.sixBit && masking);
        s_d.rampFlag = s_q.sixBit && masking;
        s_d.refUv = to_uv(s_d.refCode, s_q.sixBit);

        // ==========================================================
        // AXI4-Lite write: address and data in either order
        if (s_axi_awvalid && s_q.awReady) begin
            s_d.awTaken = 1'b1;
            s_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wReady) begin
            s_d.wTaken = 1'b1;
            s_d.wData = s_axi_wdata;
            s_d.wStrb = s_axi_wstrb;
        end
        if (s_q.awTaken && s_q.wTaken && !s_q.bValid) begin
            s_d.awTaken = 1'b0;
            s_d.wTaken = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = 2'h0;
            unique case ({s_q.awAddr[7:2], 2'b00})
                `OFS_CTRL: begin
                    if (s_q.wStrb[0]) begin
                        s_d.sixBit = s_q.wData[`CTRL_SIX_BIT];
                    end
                end
                `OFS_IRQ_ENABLE: begin
                    if (s_q.wStrb[0]) begin
                        s_d.irqEnable = s_q.wData[`IRQ_BITS-1:0];
                    end
                end
                `OFS_IRQ_CLEAR: begin
                    if (s_q.wStrb[0]) begin
                        clearBits = s_q.wData[`IRQ_BITS-1:0];
                    end
                end
                `OFS_STATUS, `OFS_REF, `OFS_IRQ_STATUS: s_d.bResp = 2'h0;
                default: s_d.bResp = 2'h2;
            endcase
        end
        if (s_q.bValid && s_axi_bready) begin
            s_d.bValid = 1'b0;
        end
        s_d.awReady = !s_d.awTaken && !s_d.bValid;
        s_d.wReady = !s_d.wTaken && !s_d.bValid;

        // AXI4-Lite read: one outstanding, data registered
        if (s_axi_arvalid && s_q.arReady) begin
            s_d.rValid = 1'b1;
            s_d.rResp = 2'h0;
            s_d.rData = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `OFS_CTRL: s_d.rData = {31'h0, s_q.sixBit};
                `OFS_STATUS: s_d.rData = {20'h0, s_q.gateEnable, s_q.powerOk, s_q.rampFlag,
                    s_q.ovFault, s_q.uvFault, s_q.ssDone, s_q.maskCnt != 6'h00, 2'h0,
                    s_q.state};
                `OFS_REF: s_d.rData = {8'h0, s_q.candidate, s_q.target, s_q.refCode};
                `OFS_IRQ_STATUS: s_d.rData = {28'h0, s_q.irqStatus};
                `OFS_IRQ_ENABLE: s_d.rData = {28'h0, s_q.irqEnable};
                `OFS_IRQ_CLEAR: s_d.rData = 32'h0000_0000;
                default: s_d.rResp = 2'h2;
            endcase
        end
        if (s_q.rValid && s_axi_rready) begin
            s_d.rValid = 1'b0;
        end
        s_d.arReady = !s_d.rValid;

        // Sticky events: a new event beats a clear in the same cycle
        s_d.irqStatus = (s_q.irqStatus & ~clearBits) | events;
        s_d.irq = |(s_d.irqStatus & s_d.irqEnable);
    end

    // ==============================================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign referenceCode = s_q.refCode;
    assign referenceMicrovolts = s_q.refUv;
    assign gateDriveEnable = s_q.gateEnable;
    assign lowSideClamp = s_q.lowClamp;
    assign overvoltageTrip = s_q.ovFault;
    assign undervoltageTrip = s_q.uvFault;
    assign powerOkOutput = s_q.powerOk;
    assign rampInProgressFlag = s_q.rampFlag;
    assign irq = s_q.irq;
    assign s_axi_awready = s_q.awReady;
    assign s_axi_wready = s_q.wReady;
    assign s_axi_bvalid = s_q.bValid;
    assign s_axi_bresp = s_q.bResp;
    assign s_axi_arready = s_q.arReady;
    assign s_axi_rvalid = s_q.rValid;
    assign s_axi_rdata = s_q.rData;
    assign s_axi_rresp = s_q.rResp;

    // ==============================================================
    // Checks on the sequencer
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_MASK_TAIL: assert property (
        (s_q.state == vid_stepper_pkg::ST_RAMP) && enabled
        ##1 (s_q.state == vid_stepper_pkg::ST_IDLE) && enabled |-> s_q.maskCnt == 6'h20)
        else $error("trip mask tail not loaded with 32 at end of ramp");
    AST_STEP_ONE: assert property (
        stepRise && enabled && (s_q.state == vid_stepper_pkg::ST_RAMP)
        |=> (s_q.refCode == $past(s_q.refCode) + 8'h01)
            || (s_q.refCode == $past(s_q.refCode) - 8'h01))
        else $error("reference step not one LSB");
    AST_CONFIRM: assert property (
        (s_q.state == vid_stepper_pkg::ST_CONFIRM) && stepFall && enabled
        && codeNow != s_q.candidate |=> s_q.state == vid_stepper_pkg::ST_IDLE)
        else $error("unconfirmed code change was accepted");
    AST_START: assert property (
        (s_q.state == vid_stepper_pkg::ST_ARMED) && stepRise && enabled
        |=> s_q.refCode != $past(s_q.refCode))
        else $error("reference did not move on first rise after confirm");
    AST_IGNORE: assert property (
        (s_q.state == vid_stepper_pkg::ST_RAMP) && enabled
        ##1 (s_q.state == vid_stepper_pkg::ST_RAMP) |-> $stable(s_q.candidate))
        else $error("code change taken during a ramp");
    AST_RATE: assert property (
        stepRise && !s_q.sixBit |-> ##25 (stepRise || s_q.sixBit))
        else $error("fast step clock period is not 25 cycles");
    AST_FLAG: assert property (
        s_q.sixBit && (s_q.maskCnt != 6'h00) ##1 s_q.sixBit |-> rampInProgressFlag)
        else $error("ramp flag low during six-bit mask tail");
    AST_TRIM: assert property (
        !$past(s_q.sixBit) && (s_q.refCode == 8'h10) |-> s_q.refUv == 21'h013C68)
        else $error("reference trim not applied");
    AST_SHUT: assert property (
        !pinSync[4] || !pinSync[3] |=> !gateDriveEnable && !lowSideClamp)
        else $error("drivers active without supplies");
    AST_DISABLE: assert property (
        !pinSync[2] |=> !powerOkOutput && !undervoltageTrip && !overvoltageTrip)
        else $error("enable low did not clear faults and power ok");
    AST_UV_LATCH: assert property (
        undervoltageTrip && enabled |=> undervoltageTrip && !gateDriveEnable)
        else $error("undervoltage fault not latched off");
    AST_PG: assert property (
        powerOkOutput |-> s_q.ssDone)
        else $error("power ok before soft start end");
endmodule

// ==== hdl/pin_sync.sv ====
// Two-flop synchroniser for a group of pin inputs
// Assumes inputs are asynchronous to ref_clk and quasi-static per bit
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_t;

    sync_t s_q, s_d;

    // ==============================================================
    // Next state: first stage feeds only the second stage
    always_comb begin
        s_d = s_q;
        s_d.meta = pinIn;
        s_d.stable = s_q.meta;
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pinOut = s_q.stable;
endmodule

// ==== hdl/step_clock_divider.sv ====
// Step clock made of rise and fall enable pulses derived from ref_clk
// Assumes ref_clk at 25 MHz; slowMode picks the slower step rate
`timescale 1ns/1ns
`include "vid_stepper_regs.svh"
module step_clock_divider #(
    parameter int FAST_DIV = `STEP_FAST_DIV,
    parameter int SLOW_DIV = `STEP_SLOW_DIV
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic slowMode,
    output logic stepRise,
    output logic stepFall
);
    typedef struct packed {
        logic [7:0] cnt;
        logic rise;
        logic fall;
    } div_t;

    div_t s_q, s_d;
    logic [7:0] lastCnt;
    logic [7:0] halfCnt;

    // ==============================================================
    // Period end and mid point for the selected rate
    always_comb begin
        lastCnt = slowMode ? 8'(SLOW_DIV - 1) : 8'(FAST_DIV - 1);
        halfCnt = slowMode ? 8'(SLOW_DIV / 2) : 8'(FAST_DIV / 2);
        s_d = s_q;
        s_d.cnt = (s_q.cnt >= lastCnt) ? 8'h00 : s_q.cnt + 8'h01;
        s_d.rise = (s_d.cnt == 8'h00);
        s_d.fall = (s_d.cnt == halfCnt);
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign stepRise = s_q.rise;
    assign stepFall = s_q.fall;
endmodule
